//--- bccd_pkg.sv
// package: field layout, encodings, bus map for the boot clock config decoder
`default_nettype none
package bccd_pkg;
    // config word one field positions
    localparam int W1_PBDIV_LSB   = 12;
    localparam int W1_CLKOEN_BIT  = 10;
    localparam int W1_POSC_LSB    = 8;
    localparam int W1_TWOSPD_BIT  = 7;
    localparam int W1_SOSC_BIT    = 5;
    localparam int W1_STARTUP_OSC_SELECT_LSB   = 0;
    // config word two field positions
    localparam int W2_PLLODIV_LSB = 16;
    localparam int W2_UPLLDIS_BIT = 15;
    localparam int W2_UPLLIDV_LSB = 8;
    localparam int W2_PLLMUL_LSB  = 4;
    localparam int W2_PLLIDIV_LSB = 0;
    // reserved masks: reserved bits must be programmed to one
    localparam logic [31:0] W1_RSVD_MASK = 32'h0000_0858;
    localparam logic [31:0] W2_RSVD_MASK = 32'hFFF8_7888;
    // apb register byte addresses
    localparam logic [7:0] ADDR_WORD_ONE = 8'h00;
    localparam logic [7:0] ADDR_WORD_TWO = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_CONTROL  = 8'h0C;
    // primary oscillator modes
    localparam logic [1:0] POSC_EXT_CLOCK = 2'h0;
    localparam logic [1:0] POSC_STD_XTAL  = 2'h1;
    localparam logic [1:0] POSC_HS_XTAL   = 2'h2;
    localparam logic [1:0] POSC_DISABLED  = 2'h3;
    // start-up source codes
    localparam logic [2:0] OSC_FAST_RC     = 3'h0;
    localparam logic [2:0] OSC_FRC_DIVN_PLL = 3'h1;
    localparam logic [2:0] OSC_PRIMARY     = 3'h2;
    localparam logic [2:0] OSC_PRIMARY_PLL = 3'h3;
    localparam logic [2:0] OSC_SECONDARY   = 3'h4;
    localparam logic [2:0] OSC_LOW_POWER_RC = 3'h5;
    localparam logic [2:0] OSC_FRC_DIV16   = 3'h6;
    localparam logic [2:0] OSC_FRC_DIVN    = 3'h7;
    // decoded clock settings handed to the clock generator
    typedef struct packed {
        logic [3:0] periph_div;      // 1,2,4,8
        logic       clock_output_en;
        logic [1:0] primary_osc_mode;
        logic       hs_xtal;
        logic       std_xtal;
        logic       ext_clock;
        logic       primary_on;
        logic       two_speed_startup_en;
        logic       secondary_osc_on;
        logic [2:0] startup_osc_select;
        logic       use_pll;
        logic [8:0] pll_postscale;   // 1..256
        logic       usb_pll_on;
        logic [3:0] usb_pll_in_div;  // 1..12
        logic [4:0] pll_mult;        // 15..24
        logic [3:0] pll_in_div;      // 1..12
    } bccd_clk_cfg_t;
endpackage
`default_nettype wire

//--- bccd_decode.sv
// combinational decoder from two config words to clock settings
`default_nettype none
module bccd_decode
    import bccd_pkg::*;
(
    // raw words
    input  wire logic [31:0]   word_one,
    input  wire logic [31:0]   word_two,
    // decoded settings
    output bccd_clk_cfg_t      cfg
);
    // shared by both pll input dividers
    function automatic logic [3:0] in_div(input logic [2:0] c);
        case (c)
            3'h6:    in_div = 4'hA;
            3'h7:    in_div = 4'hC;
            default: in_div = {1'b0, c} + 4'h1;
        endcase
    endfunction

    logic [1:0] posc;
    logic [2:0] mul_code;
    logic [2:0] odiv;
    assign posc     = word_one[W1_POSC_LSB +: 2];
    assign mul_code = word_two[W2_PLLMUL_LSB +: 3];
    assign odiv     = word_two[W2_PLLODIV_LSB +: 3];

    // field decode
    always_comb begin
        cfg = '0;
        cfg.periph_div = 4'h1 << word_one[W1_PBDIV_LSB +: 2];
        // clock output only with primary off or external clock
        cfg.clock_output_en = word_one[W1_CLKOEN_BIT] &&
            (posc == POSC_DISABLED || posc == POSC_EXT_CLOCK);
        cfg.primary_osc_mode = posc;
        cfg.hs_xtal    = (posc == POSC_HS_XTAL);
        cfg.std_xtal   = (posc == POSC_STD_XTAL);
        cfg.ext_clock  = (posc == POSC_EXT_CLOCK);
        cfg.primary_on = (posc != POSC_DISABLED);
        cfg.two_speed_startup_en = word_one[W1_TWOSPD_BIT];
        cfg.secondary_osc_on = word_one[W1_SOSC_BIT];
        cfg.startup_osc_select = word_one[W1_STARTUP_OSC_SELECT_LSB +: 3];
        cfg.use_pll = (cfg.startup_osc_select == OSC_PRIMARY_PLL) ||
                      (cfg.startup_osc_select == OSC_FRC_DIVN_PLL);
        // code 7 jumps to 256, not 128
        cfg.pll_postscale = (odiv == 3'h7) ? 9'h100 : (9'h001 << odiv);
        cfg.usb_pll_on = ~word_two[W2_UPLLDIS_BIT];
        cfg.usb_pll_in_div = in_div(word_two[W2_UPLLIDV_LSB +: 3]);
        cfg.pll_mult = (mul_code == 3'h7) ? 5'h18 : 5'h0F + {2'h0, mul_code};
        cfg.pll_in_div = in_div(word_two[W2_PLLIDIV_LSB +: 3]);
    end
endmodule
`default_nettype wire

//--- bccd_top.sv
// boot clock config decoder: latches config words on the first clock after reset, apb readback
//
// Decided for this implementation: the register addresses and register access over APB.
`default_nettype none
//
// Contract
// - Peripheral divisor codes 11,10,01,00 give system clock divided by 8,4,2,1.
// - Clock output is driven only when enabled and primary mode is disabled or external.
// - Primary mode codes 11,10,01,00 mean disabled, high-speed, standard crystal, external.
// - The switchover bit enables two-speed start-up.
// - The secondary enable bit turns the secondary oscillator on.
// - The three-bit select field picks the start-up source among eight.
// - Postscaler codes 0..7 divide by 1,2,4,8,16,32,64,256.
// - USB PLL bit one disables and bypasses it, zero enables it.
// - USB PLL input divider codes 0..7 divide by 1,2,3,4,5,6,10,12.
// - PLL multiplier codes 0..7 multiply by 15..21 then 24.
// - PLL input divider codes 0..7 divide by 1,2,3,4,5,6,10,12.
module bccd_top
    import bccd_pkg::*;
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // nonvolatile config words
    input  wire logic [31:0]   nv_word_one,
    input  wire logic [31:0]   nv_word_two,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // to clock generator and core
    output bccd_clk_cfg_t      clk_cfg,
    output logic               cfg_valid,
    output logic               core_reset_n
);
    typedef enum logic [1:0] {
        BCCD_LATCH,
        BCCD_APPLY,
        BCCD_RUN
    } bccd_state_t;

    bccd_state_t    state_q, state_d;
    logic [31:0]    word_one_q, word_one_d;
    logic [31:0]    word_two_q, word_two_d;
    logic [31:0]    prdata_q, prdata_d;
    logic           pslverr_q, pslverr_d;
    logic           hold_core_q, hold_core_d;
    bccd_clk_cfg_t  cfg_now;
    logic           rsvd_err;
    logic           src_err;
    logic           access;

    bccd_decode u_decode (
        .word_one (word_one_q),
        .word_two (word_two_q),
        .cfg      (cfg_now)
    );

    // programming errors the device can only flag, not fix
    assign rsvd_err = ((word_one_q & W1_RSVD_MASK) != W1_RSVD_MASK) ||
                      ((word_two_q & W2_RSVD_MASK) != W2_RSVD_MASK);
    assign src_err  = (cfg_now.startup_osc_select == OSC_PRIMARY ||
                       cfg_now.startup_osc_select == OSC_PRIMARY_PLL) &&
                      !cfg_now.primary_on;

    // startup sequence: latch once, apply, then release core
    always_comb begin
        state_d     = state_q;
        word_one_d  = word_one_q;
        word_two_d  = word_two_q;
        hold_core_d = hold_core_q;
        case (state_q)
            BCCD_LATCH: begin
                word_one_d = nv_word_one;
                word_two_d = nv_word_two;
                state_d    = BCCD_APPLY;
            end
            BCCD_APPLY: begin
                state_d = BCCD_RUN;
            end
            BCCD_RUN: begin
                hold_core_d = 1'b0;
            end
            default: begin
                state_d = BCCD_LATCH;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q     <= BCCD_LATCH;
            word_one_q  <= '1;
            word_two_q  <= '1;
            hold_core_q <= 1'b1;
        end else begin
            state_q     <= state_d;
            word_one_q  <= word_one_d;
            word_two_q  <= word_two_d;
            hold_core_q <= hold_core_d;
        end
    end

    // settings driven straight from the decoder, so the generator sees decoded reset filler until latch; cfg_valid flags them
    assign clk_cfg      = cfg_now;
    assign cfg_valid    = (state_q == BCCD_RUN);
    assign core_reset_n = ~hold_core_q;

    // apb: zero wait states, words read-only
    assign access  = psel && penable;
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    always_comb begin
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (psel && !penable) begin
            prdata_d = '0;
            case (paddr)
                ADDR_WORD_ONE: prdata_d = word_one_q;
                ADDR_WORD_TWO: prdata_d = word_two_q;
                ADDR_STATUS:   prdata_d = {29'h0, src_err, rsvd_err, cfg_valid};
                default:       prdata_d = '0;
            endcase
        end
        // writes refused: the words are fixed by the programmer
        if (access) begin
            pslverr_d = pwrite || !(paddr == ADDR_WORD_ONE ||
                        paddr == ADDR_WORD_TWO || paddr == ADDR_STATUS);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // checks
    pbdiv_decode_a: assert property (@(posedge clk) disable iff (!reset_n)
        cfg_valid |-> clk_cfg.periph_div ==
            (4'h1 << word_one_q[W1_PBDIV_LSB +: 2]))
        else $error("periph divisor wrong");
    clkout_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_cfg.clock_output_en |-> (clk_cfg.primary_osc_mode == POSC_DISABLED ||
            clk_cfg.primary_osc_mode == POSC_EXT_CLOCK))
        else $error("clock out in crystal mode");
    posc_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_cfg.primary_on == (word_one_q[W1_POSC_LSB +: 2] != POSC_DISABLED))
        else $error("primary mode decode wrong");
    two_speed_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_cfg.two_speed_startup_en == word_one_q[W1_TWOSPD_BIT])
        else $error("two speed wrong");
    sosc_en_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_cfg.secondary_osc_on == word_one_q[W1_SOSC_BIT])
        else $error("secondary enable wrong");
    postscale_a: assert property (@(posedge clk) disable iff (!reset_n)
        word_two_q[W2_PLLODIV_LSB +: 3] == 3'h7 |-> clk_cfg.pll_postscale == 9'h100)
        else $error("postscaler top code wrong");
    usb_pll_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_cfg.usb_pll_on != word_two_q[W2_UPLLDIS_BIT])
        else $error("usb pll polarity wrong");
    mult_range_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_cfg.pll_mult >= 5'h0F && clk_cfg.pll_mult <= 5'h18 && clk_cfg.pll_mult != 5'h16)
        else $error("multiplier out of set");
    in_div_a: assert property (@(posedge clk) disable iff (!reset_n)
        word_two_q[W2_PLLIDIV_LSB +: 3] == 3'h6 |-> clk_cfg.pll_in_div == 4'hA)
        else $error("pll input divider wrong");
    usb_div_a: assert property (@(posedge clk) disable iff (!reset_n)
        word_two_q[W2_UPLLIDV_LSB +: 3] == 3'h7 |-> clk_cfg.usb_pll_in_div == 4'hC)
        else $error("usb input divider wrong");
    release_seq_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(core_reset_n) |-> $past(cfg_valid) && word_one_q == $past(word_one_q))
        else $error("core released before apply");
    src_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_cfg.startup_osc_select == word_one_q[W1_STARTUP_OSC_SELECT_LSB +: 3])
        else $error("source select wrong");
endmodule
`default_nettype wire

//--- bccd_top_tb.sv
// self-checking bench for the boot clock config decoder
`default_nettype none
`define CHK(a, b) begin \
    samples_checked++; \
    if ((a) !== (b)) begin \
        n_errors++; \
        $display("mismatch at %0t got %h expected %h", $time, (a), (b)); \
    end \
end
module bccd_top_tb
    import bccd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // decode tables kept apart from the design's own logic
    localparam logic [3:0] PBDIV_T [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    localparam logic [8:0] POST_T  [8] = '{9'h001, 9'h002, 9'h004, 9'h008,
                                           9'h010, 9'h020, 9'h040, 9'h100};
    localparam logic [3:0] IDIV_T  [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hC};
    localparam logic [4:0] MUL_T   [8] = '{5'h0F, 5'h10, 5'h11, 5'h12,
                                           5'h13, 5'h14, 5'h15, 5'h18};
    // stimulus and observed signals
    logic          clk;
    logic          reset_n;
    logic [31:0]   nv_word_one;
    logic [31:0]   nv_word_two;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    bccd_clk_cfg_t cfg;
    logic          cfg_valid;
    logic          core_reset_n;
    int            n_errors;
    int            samples_checked;

    bccd_top uut (
        .clk          (clk),
        .reset_n      (reset_n),
        .nv_word_one  (nv_word_one),
        .nv_word_two  (nv_word_two),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .clk_cfg      (cfg),
        .cfg_valid    (cfg_valid),
        .core_reset_n (core_reset_n)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // reset, then watch latch, apply and core release edge by edge
    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        `CHK({cfg_valid, core_reset_n, prdata}, 34'h0)
        @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(cfg_valid, 1'b0)
        @(posedge clk);
        #1;
        `CHK({cfg_valid, core_reset_n}, 2'h2)
        @(posedge clk);
        #1;
        `CHK({cfg_valid, core_reset_n}, 2'h3)
    endtask

    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        `CHK(pready, 1'b1)
    endtask

    // every code of every field, words read back over the bus
    task automatic t_decode();
        logic [2:0]  c;
        logic [1:0]  m;
        logic [31:0] rd;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            m = c[1:0];
            nv_word_one <= W1_RSVD_MASK | {18'h0, ~m, 1'b0, c[2], m, c[0], 1'b0, c[1], 2'h0, c};
            nv_word_two <= W2_RSVD_MASK | {13'h0, c, c[0], 4'h0, ~c, 1'b0, c, 1'b0, ~c};
            do_reset();
            `CHK(cfg.periph_div, PBDIV_T[~m])
            `CHK(cfg.clock_output_en, c[2] & (m == POSC_DISABLED || m == POSC_EXT_CLOCK))
            `CHK(cfg.primary_osc_mode, m)
            `CHK({cfg.hs_xtal, cfg.std_xtal, cfg.ext_clock}, {m == 2'h2, m == 2'h1, m == 2'h0})
            `CHK(cfg.two_speed_startup_en, c[0])
            `CHK(cfg.secondary_osc_on, c[1])
            `CHK(cfg.startup_osc_select, c)
            `CHK(cfg.pll_postscale, POST_T[c])
            `CHK(cfg.usb_pll_on, ~c[0])
            `CHK(cfg.usb_pll_in_div, IDIV_T[~c])
            `CHK(cfg.pll_mult, MUL_T[c])
            `CHK(cfg.pll_in_div, IDIV_T[~c])
            apb(1'b0, ADDR_WORD_ONE, 32'h0, rd);
            `CHK(rd, nv_word_one)
            apb(1'b0, ADDR_WORD_TWO, 32'h0, rd);
            `CHK(rd, nv_word_two)
        end
        $display("test decode done");
    endtask

    // read-only word one, status flags, unmapped places
    task automatic t_regs();
        logic [31:0] rd;
        nv_word_one <= W1_RSVD_MASK;
        nv_word_two <= W2_RSVD_MASK;
        do_reset();
        apb(1'b0, ADDR_STATUS, 32'h0, rd);
        `CHK(rd, 32'h0000_0001)
        // error flag is registered: visible the cycle after the access edge
        #1;
        `CHK(pslverr, 1'b0)
        apb(1'b1, ADDR_WORD_ONE, 32'h0, rd);
        #1;
        `CHK(pslverr, 1'b1)
        apb(1'b0, ADDR_WORD_ONE, 32'h0, rd);
        `CHK(rd, W1_RSVD_MASK)
        apb(1'b0, ADDR_CONTROL, 32'h0, rd);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h40, 32'h0, rd);
        `CHK(rd, 32'h0)
        #1;
        `CHK(pslverr, 1'b1)
        // programmer fault: reserved bits clear, disabled primary selected
        nv_word_one <= 32'h0000_0302;
        do_reset();
        apb(1'b0, ADDR_STATUS, 32'h0, rd);
        `CHK(rd, 32'h0000_0007)
        $display("test regs done");
    endtask

    // watchdog: the whole run needs about 160 cycles
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end

    initial begin
        n_errors        = 0;
        samples_checked = 0;
        reset_n         = 1'b0;
        nv_word_one     = 32'hFFFF_FFFF;
        nv_word_two     = 32'hFFFF_FFFF;
        psel            = 1'b0;
        penable         = 1'b0;
        pwrite          = 1'b0;
        paddr           = 8'h00;
        pwdata          = 32'h0;
        t_decode();
        t_regs();
        end_sim();
    end
endmodule
`default_nettype wire
